// [include/uef_pkg.sv]
package uef_pkg;
	// ****************************************
	// Register select codes
	// ****************************************
	localparam logic [3:0] REG_FLAG0 = 4'h0;
	localparam logic [3:0] REG_FLAG1 = 4'h1;
	localparam logic [3:0] REG_SEL0  = 4'h2;
	localparam logic [3:0] REG_SEL1  = 4'h3;
	localparam logic [3:0] REG_IEN0  = 4'h4;
	localparam logic [3:0] REG_IEN1  = 4'h5;
	localparam logic [3:0] REG_EP0I  = 4'h6;
	localparam logic [3:0] REG_EP0O  = 4'h7;
	localparam logic [3:0] REG_SETUP = 4'h8;
	localparam logic [3:0] REG_EP1   = 4'h9;
	localparam logic [3:0] REG_EP2   = 4'hA;
	localparam logic [3:0] REG_EP3   = 4'hB;
	localparam logic [3:0] REG_SZ0   = 4'hC;
	localparam logic [3:0] REG_SZ1   = 4'hD;
	localparam logic [3:0] REG_TRIG  = 4'hE;
	localparam logic [3:0] REG_FIFO_CLEAR_REG  = 4'hF;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int FL0_BUS_RESET = 7;
	localparam int FL0_RX_FULL   = 6;
	localparam int FL0_TX_REQ    = 5;
	localparam int FL0_TX_EMPTY  = 4;
	localparam int FL0_SETUP_RX  = 3;
	localparam int FL0_CTRL_RX   = 2;
	localparam int FL0_CIN_REQ   = 1;
	localparam int FL0_CIN_SENT  = 0;
	localparam int FL1_INT_REQ   = 2;
	localparam int FL1_INT_SENT  = 1;
	localparam int FL1_CONNECT   = 0;
	localparam int TRG_INT_COMMIT = 6;
	localparam int TRG_RX_DONE    = 5;
	localparam int TRG_TX_COMMIT  = 4;
	localparam int TRG_SETUP_DONE = 2;
	localparam int TRG_CTRL_DONE  = 1;
	localparam int TRG_CIN_COMMIT = 0;
	localparam int CLR_INTR    = 6;
	localparam int CLR_BULK_RX = 5;
	localparam int CLR_BULK_TX = 4;
	localparam int CLR_CTRL_RX = 1;
	localparam int CLR_CTRL_TX = 0;
	// ****************************************
	// Reset values and sizes
	// ****************************************
	localparam logic [7:0] IEN0_RST = 8'h10;
	localparam logic [2:0] IEN1_RST = 3'h0;
	localparam logic [7:0] SEL0_RST = 8'h00;
	localparam logic [2:0] SEL1_RST = 3'h7;
	localparam logic [6:0] CTRL_BYTES = 7'h08;
	localparam logic [6:0] BULK_PKT   = 7'h40;
	localparam logic [1:0] EP_CTRL    = 2'h0;
	localparam logic [1:0] EP_BULK_RX = 2'h1;
	localparam logic [1:0] EP_BULK_TX = 2'h2;
	localparam logic [1:0] EP_INTR    = 2'h3;
	typedef enum logic [1:0] {KIND_SETUP = 2'b00, KIND_OUT = 2'b01, KIND_IN = 2'b10} uef_kind_e;
	typedef enum logic [1:0] {
		DS_IDLE = 2'b00, DS_RECV = 2'b01, DS_SEND = 2'b10, DS_WAIT_ACK = 2'b11
	} uef_dev_state_e;
	typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_DATA = 2'b01, HS_WAIT = 2'b10} uef_host_state_e;
endpackage

// [include/uef_link_if.sv]
`timescale 1ns/1ps
interface uef_link_if;
	import uef_pkg::*;
	logic      bus_reset;
	logic      start;
	uef_kind_e kind;
	logic [1:0] ep;
	logic      h2d_valid;
	logic [7:0] h2d_data;
	logic      h2d_end;
	logic      h2d_ok;
	logic      h2d_ack;
	logic      d2h_valid;
	logic [7:0] d2h_data;
	logic      d2h_done;
	logic      d2h_ack;
	logic      d2h_nak;
	modport dev (
		input  bus_reset, start, kind, ep, h2d_valid, h2d_data, h2d_end, h2d_ok, h2d_ack,
		output d2h_valid, d2h_data, d2h_done, d2h_ack, d2h_nak
	);
	modport hst (
		output bus_reset, start, kind, ep, h2d_valid, h2d_data, h2d_end, h2d_ok, h2d_ack,
		input  d2h_valid, d2h_data, d2h_done, d2h_ack, d2h_nak
	);
endinterface

// [hw/uef_dev.sv]
`timescale 1ns/1ps
// Behaviour
// - Enabled set flag raises CPU interrupt
// - Select bit steers request to vector
// - Upper five enable bits read zero
// - Eight-byte single-packet control-in transmit buffer
// - Commit trigger fixes control-in packet
// - Host ACK sets control-in sent flag
// - Clear bit empties that endpoint buffer
// - Eight-byte control-out receive buffer, no setup
// - Good OUT sets flag, loads size
// - Next OUT refused until read done
// - Separate setup buffer, flag on good
// - New setup overwrites unread setup bytes
// - Setup arrival aborts software setup read
// - Bulk receive 128 bytes, two halves
// - Good bulk packet sets full, size
// - Read done frees only drained half
// - DMA reads bulk rx, writes bulk tx
// - Bulk tx dual halves, commit swaps
// - Interrupt endpoint single packet, ACK flag
// - Control-out size register resets zero
// - Bulk size shows current read half, zero if empty
// - Write zero clears flag, one keeps
// - Buffer clear leaves flags alone
module uef_dev
	import uef_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       ce_in,
	// Link toward the USB host
	uef_link_if.dev         link,
	// CPU register port
	input  wire logic [3:0] reg_sel_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	// DMA port
	input  wire logic       dma_rd_in,
	input  wire logic       dma_wr_in,
	input  wire logic [7:0] dma_wdata_in,
	output logic      [7:0] dma_rdata_out,
	// Pin and interrupt vectors
	input  wire logic       bus_connect_change_in,
	output logic            irq0_out,
	output logic            irq1_out
);
	// ****************************************
	// State
	// ****************************************
	uef_dev_state_e st_reg;
	uef_kind_e      rx_kind_reg;
	logic [1:0]     rx_ep_reg;
	logic           rx_drop_reg;
	logic [6:0]     rx_cnt_reg;
	logic [6:0]     tx_idx_reg;
	logic [7:0]     flag0_reg, ien0_reg, sel0_reg;
	logic [2:0]     flag1_reg, ien1_reg, sel1_reg;
	logic           vb1_reg, vb2_reg, vb3_reg, bus_connect_change_lvl_reg;
	logic [7:0]     setup_mem [0:7];
	logic [7:0]     ep0o_mem [0:7];
	logic [7:0]     ep0i_mem [0:7];
	logic [7:0]     ep3_mem [0:7];
	logic [7:0]     ep1_mem [0:127];
	logic [7:0]     ep2_mem [0:127];
	logic           ep0i_valid_reg, ep3_valid_reg, ep0o_full_reg, setup_hold_reg;
	logic [6:0]     ep0i_wp_reg, ep3_wp_reg;
	logic [2:0]     ep0o_rp_reg, setup_rp_reg;
	logic [7:0]     ep0o_size_reg;
	logic [1:0]     ep1_full_reg, ep2_valid_reg;
	logic [6:0]     ep1_len_reg [0:1];
	logic [6:0]     ep2_len_reg [0:1];
	logic           ep1_rx_half_reg, ep1_rd_half_reg, ep2_wr_half_reg, ep2_tx_half_reg;
	logic [5:0]     ep1_rp_reg;
	logic [6:0]     ep2_wp_reg;

	function automatic logic wr_hit(input logic [3:0] idx);
		wr_hit = reg_wr_in && (reg_sel_in == idx);
	endfunction
	function automatic logic rd_hit(input logic [3:0] idx);
		rd_hit = reg_rd_in && (reg_sel_in == idx);
	endfunction

	// ****************************************
	// Decode of link and register events
	// ****************************************
	logic [7:0] trg, fifo_clear_reg, ev0, ep2_wdata, ep1_byte;
	logic [2:0] ev1;
	logic       start_ok, out_busy, in_ready, rx_good, rx_wr, ack_ev, setup_busy;
	logic       w_ep0i, w_ep2, w_ep3, r_ep0o, r_setup, r_ep1, vb_change;
	logic [6:0] rx_cap, tx_len;
	logic [7:0] tx_byte;
	always_comb
	begin
		trg = wr_hit(REG_TRIG) ? reg_wdata_in : 8'h00;
		fifo_clear_reg = wr_hit(REG_FIFO_CLEAR_REG) ? reg_wdata_in : 8'h00;
		start_ok = link.start && (st_reg == DS_IDLE || st_reg == DS_WAIT_ACK);
		unique case (link.ep)
			EP_CTRL:    out_busy = ep0o_full_reg || setup_hold_reg;
			EP_BULK_RX: out_busy = ep1_full_reg[ep1_rx_half_reg];
			default:    out_busy = 1'b1;
		endcase
		if (link.kind == KIND_SETUP)
			out_busy = 1'b0;
		unique case (link.ep)
			EP_CTRL:    in_ready = ep0i_valid_reg && !setup_hold_reg;
			EP_BULK_TX: in_ready = ep2_valid_reg[ep2_tx_half_reg];
			EP_INTR:    in_ready = ep3_valid_reg;
			default:    in_ready = 1'b0;
		endcase
		rx_cap = (rx_kind_reg == KIND_OUT && rx_ep_reg == EP_BULK_RX) ? BULK_PKT : CTRL_BYTES;
		rx_wr = st_reg == DS_RECV && link.h2d_valid && !rx_drop_reg && rx_cnt_reg < rx_cap;
		rx_good = st_reg == DS_RECV && link.h2d_end && link.h2d_ok && !rx_drop_reg
			&& rx_cnt_reg <= rx_cap;
		ack_ev = st_reg == DS_WAIT_ACK && link.h2d_ack;
		setup_busy = st_reg == DS_RECV && rx_kind_reg == KIND_SETUP;
		unique case (rx_ep_reg)
			EP_CTRL:    tx_len = ep0i_wp_reg;
			EP_BULK_TX: tx_len = ep2_len_reg[ep2_tx_half_reg];
			default:    tx_len = ep3_wp_reg;
		endcase
		unique case (rx_ep_reg)
			EP_CTRL:    tx_byte = ep0i_mem[tx_idx_reg[2:0]];
			EP_BULK_TX: tx_byte = ep2_mem[{ep2_tx_half_reg, tx_idx_reg[5:0]}];
			default:    tx_byte = ep3_mem[tx_idx_reg[2:0]];
		endcase
		w_ep0i = wr_hit(REG_EP0I) && !ep0i_valid_reg && ep0i_wp_reg < CTRL_BYTES;
		w_ep3 = wr_hit(REG_EP3) && !ep3_valid_reg && ep3_wp_reg < CTRL_BYTES;
		w_ep2 = (wr_hit(REG_EP2) || dma_wr_in) && !ep2_valid_reg[ep2_wr_half_reg]
			&& ep2_wp_reg < BULK_PKT;
		ep2_wdata = wr_hit(REG_EP2) ? reg_wdata_in : dma_wdata_in;
		r_ep0o = rd_hit(REG_EP0O);
		r_setup = rd_hit(REG_SETUP) && !setup_busy;
		r_ep1 = rd_hit(REG_EP1) || dma_rd_in;
		ep1_byte = ep1_mem[{ep1_rd_half_reg, ep1_rp_reg}];
		vb_change = (vb2_reg == vb3_reg) && (vb3_reg != bus_connect_change_lvl_reg);
		ev0 = 8'h00;
		ev0[FL0_BUS_RESET] = link.bus_reset;
		ev0[FL0_RX_FULL] = rx_good && rx_kind_reg == KIND_OUT && rx_ep_reg == EP_BULK_RX;
		ev0[FL0_TX_REQ] = start_ok && link.kind == KIND_IN && link.ep == EP_BULK_TX && !in_ready;
		ev0[FL0_TX_EMPTY] = ack_ev && rx_ep_reg == EP_BULK_TX;
		ev0[FL0_SETUP_RX] = rx_good && rx_kind_reg == KIND_SETUP;
		ev0[FL0_CTRL_RX] = rx_good && rx_kind_reg == KIND_OUT && rx_ep_reg == EP_CTRL;
		ev0[FL0_CIN_REQ] = start_ok && link.kind == KIND_IN && link.ep == EP_CTRL
			&& !ep0i_valid_reg;
		ev0[FL0_CIN_SENT] = ack_ev && rx_ep_reg == EP_CTRL;
		ev1[FL1_INT_REQ] = start_ok && link.kind == KIND_IN && link.ep == EP_INTR
			&& !ep3_valid_reg;
		ev1[FL1_INT_SENT] = ack_ev && rx_ep_reg == EP_INTR;
		ev1[FL1_CONNECT] = vb_change;
	end

	// ****************************************
	// Link sequencer
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_reg <= DS_IDLE;
			rx_kind_reg <= KIND_SETUP;
			rx_ep_reg <= 2'h0;
			rx_drop_reg <= 1'b0;
			rx_cnt_reg <= 7'h00;
			tx_idx_reg <= 7'h00;
			link.d2h_valid <= 1'b0;
			link.d2h_data <= 8'h00;
			link.d2h_done <= 1'b0;
			link.d2h_ack <= 1'b0;
			link.d2h_nak <= 1'b0;
		end
		else if (ce_in)
		begin
			link.d2h_valid <= 1'b0;
			link.d2h_done <= 1'b0;
			link.d2h_ack <= 1'b0;
			link.d2h_nak <= 1'b0;
			unique case (st_reg)
				DS_IDLE, DS_WAIT_ACK:
					if (start_ok)
					begin
						rx_kind_reg <= link.kind;
						rx_ep_reg <= link.ep;
						rx_cnt_reg <= 7'h00;
						tx_idx_reg <= 7'h00;
						rx_drop_reg <= out_busy;
						if (link.kind != KIND_IN)
							st_reg <= DS_RECV;
						else if (in_ready)
							st_reg <= DS_SEND;
						else
						begin
							link.d2h_nak <= 1'b1;
							st_reg <= DS_IDLE;
						end
					end
					else if (ack_ev)
						st_reg <= DS_IDLE;
				DS_RECV:
				begin
					if (link.h2d_valid && rx_cnt_reg != 7'h7F)
						rx_cnt_reg <= rx_cnt_reg + 7'h01;
					if (link.h2d_end)
					begin
						link.d2h_ack <= rx_good;
						link.d2h_nak <= link.h2d_ok && rx_drop_reg;
						st_reg <= DS_IDLE;
					end
				end
				DS_SEND:
					if (tx_idx_reg == tx_len)
					begin
						link.d2h_done <= 1'b1;
						st_reg <= DS_WAIT_ACK;
					end
					else
					begin
						link.d2h_valid <= 1'b1;
						link.d2h_data <= tx_byte;
						tx_idx_reg <= tx_idx_reg + 7'h01;
					end
			endcase
		end
	end

	// ****************************************
	// Buffer storage
	// ****************************************
	always_ff @(posedge ref_clk_in)
	begin
		if (ce_in)
		begin
			if (rx_wr && rx_kind_reg == KIND_SETUP)
				setup_mem[rx_cnt_reg[2:0]] <= link.h2d_data;
			if (rx_wr && rx_kind_reg == KIND_OUT && rx_ep_reg == EP_CTRL)
				ep0o_mem[rx_cnt_reg[2:0]] <= link.h2d_data;
			if (rx_wr && rx_kind_reg == KIND_OUT && rx_ep_reg == EP_BULK_RX)
				ep1_mem[{ep1_rx_half_reg, rx_cnt_reg[5:0]}] <= link.h2d_data;
			if (w_ep0i)
				ep0i_mem[ep0i_wp_reg[2:0]] <= reg_wdata_in;
			if (w_ep3)
				ep3_mem[ep3_wp_reg[2:0]] <= reg_wdata_in;
			if (w_ep2)
				ep2_mem[{ep2_wr_half_reg, ep2_wp_reg[5:0]}] <= ep2_wdata;
		end
	end

	// ****************************************
	// Transmit endpoints
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ep0i_valid_reg <= 1'b0;
			ep0i_wp_reg <= 7'h00;
			ep3_valid_reg <= 1'b0;
			ep3_wp_reg <= 7'h00;
		end
		else if (ce_in)
		begin
			if (fifo_clear_reg[CLR_CTRL_TX] || ev0[FL0_CIN_SENT])
			begin
				ep0i_valid_reg <= 1'b0;
				ep0i_wp_reg <= 7'h00;
			end
			else if (trg[TRG_CIN_COMMIT])
				ep0i_valid_reg <= 1'b1;
			else if (w_ep0i)
				ep0i_wp_reg <= ep0i_wp_reg + 7'h01;
			if (fifo_clear_reg[CLR_INTR] || ev1[FL1_INT_SENT])
			begin
				ep3_valid_reg <= 1'b0;
				ep3_wp_reg <= 7'h00;
			end
			else if (trg[TRG_INT_COMMIT])
				ep3_valid_reg <= 1'b1;
			else if (w_ep3)
				ep3_wp_reg <= ep3_wp_reg + 7'h01;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ep2_valid_reg <= 2'h0;
			ep2_len_reg[0] <= 7'h00;
			ep2_len_reg[1] <= 7'h00;
			ep2_wr_half_reg <= 1'b0;
			ep2_tx_half_reg <= 1'b0;
			ep2_wp_reg <= 7'h00;
		end
		else if (ce_in)
		begin
			if (fifo_clear_reg[CLR_BULK_TX])
			begin
				ep2_valid_reg <= 2'h0;
				ep2_wr_half_reg <= 1'b0;
				ep2_tx_half_reg <= 1'b0;
				ep2_wp_reg <= 7'h00;
			end
			else
			begin
				if (trg[TRG_TX_COMMIT] && !ep2_valid_reg[ep2_wr_half_reg])
				begin
					ep2_valid_reg[ep2_wr_half_reg] <= 1'b1;
					ep2_len_reg[ep2_wr_half_reg] <= ep2_wp_reg;
					ep2_wr_half_reg <= !ep2_wr_half_reg;
					ep2_wp_reg <= 7'h00;
				end
				else if (w_ep2)
					ep2_wp_reg <= ep2_wp_reg + 7'h01;
				if (ev0[FL0_TX_EMPTY])
				begin
					ep2_valid_reg[ep2_tx_half_reg] <= 1'b0;
					ep2_tx_half_reg <= !ep2_tx_half_reg;
				end
			end
		end
	end

	// ****************************************
	// Receive endpoints
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ep0o_full_reg <= 1'b0;
			ep0o_rp_reg <= 3'h0;
			ep0o_size_reg <= 8'h00;
			setup_hold_reg <= 1'b0;
			setup_rp_reg <= 3'h0;
		end
		else if (ce_in)
		begin
			// flag and size on good OUT
			if (fifo_clear_reg[CLR_CTRL_RX])
			begin
				ep0o_full_reg <= 1'b0;
				ep0o_rp_reg <= 3'h0;
			end
			else if (ev0[FL0_CTRL_RX])
			begin
				ep0o_full_reg <= 1'b1;
				ep0o_rp_reg <= 3'h0;
				ep0o_size_reg <= {1'b0, rx_cnt_reg};
			end
			else if (trg[TRG_CTRL_DONE])
			begin
				ep0o_full_reg <= 1'b0;
				ep0o_rp_reg <= 3'h0;
			end
			else if (r_ep0o)
				ep0o_rp_reg <= ep0o_rp_reg + 3'h1;
			if (ev0[FL0_SETUP_RX])
				setup_hold_reg <= 1'b1;
			else if (trg[TRG_SETUP_DONE])
				setup_hold_reg <= 1'b0;
			if (start_ok && link.kind == KIND_SETUP)
				setup_rp_reg <= 3'h0;
			else if (r_setup)
				setup_rp_reg <= setup_rp_reg + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ep1_full_reg <= 2'h0;
			ep1_len_reg[0] <= 7'h00;
			ep1_len_reg[1] <= 7'h00;
			ep1_rx_half_reg <= 1'b0;
			ep1_rd_half_reg <= 1'b0;
			ep1_rp_reg <= 6'h00;
		end
		else if (ce_in)
		begin
			if (fifo_clear_reg[CLR_BULK_RX])
			begin
				ep1_full_reg <= 2'h0;
				ep1_rx_half_reg <= 1'b0;
				ep1_rd_half_reg <= 1'b0;
				ep1_rp_reg <= 6'h00;
			end
			else
			begin
				if (ev0[FL0_RX_FULL])
				begin
					ep1_full_reg[ep1_rx_half_reg] <= 1'b1;
					ep1_len_reg[ep1_rx_half_reg] <= rx_cnt_reg;
					ep1_rx_half_reg <= !ep1_rx_half_reg;
				end
				if (trg[TRG_RX_DONE] && ep1_full_reg[ep1_rd_half_reg])
				begin
					ep1_full_reg[ep1_rd_half_reg] <= 1'b0;
					ep1_rd_half_reg <= !ep1_rd_half_reg;
					ep1_rp_reg <= 6'h00;
				end
				else if (r_ep1)
					ep1_rp_reg <= ep1_rp_reg + 6'h01;
			end
		end
	end

	// ****************************************
	// Interrupt registers and vectors
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			flag0_reg <= 8'h00;
			flag1_reg <= 3'h0;
			ien0_reg <= IEN0_RST;
			ien1_reg <= IEN1_RST;
			sel0_reg <= SEL0_RST;
			sel1_reg <= SEL1_RST;
			irq0_out <= 1'b0;
			irq1_out <= 1'b0;
		end
		else if (ce_in)
		begin
			// zero clears, set wins; clears untouched
			flag0_reg <= (wr_hit(REG_FLAG0) ? flag0_reg & reg_wdata_in : flag0_reg) | ev0;
			flag1_reg <= (wr_hit(REG_FLAG1) ? flag1_reg & reg_wdata_in[2:0] : flag1_reg) | ev1;
			if (wr_hit(REG_IEN0))
				ien0_reg <= reg_wdata_in;
			if (wr_hit(REG_IEN1))
				ien1_reg <= reg_wdata_in[2:0];
			if (wr_hit(REG_SEL0))
				sel0_reg <= reg_wdata_in;
			if (wr_hit(REG_SEL1))
				sel1_reg <= reg_wdata_in[2:0];
			irq0_out <= |(flag0_reg & ien0_reg & ~sel0_reg) | |(flag1_reg & ien1_reg & ~sel1_reg);
			irq1_out <= |(flag0_reg & ien0_reg & sel0_reg) | |(flag1_reg & ien1_reg & sel1_reg);
		end
	end

	// ****************************************
	// Bus connect pin and read data
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			vb1_reg <= 1'b0;
			vb2_reg <= 1'b0;
			vb3_reg <= 1'b0;
			bus_connect_change_lvl_reg <= 1'b0;
			reg_rdata_out <= 8'h00;
			dma_rdata_out <= 8'h00;
		end
		else if (ce_in)
		begin
			vb1_reg <= bus_connect_change_in;
			vb2_reg <= vb1_reg;
			vb3_reg <= vb2_reg;
			if (vb_change)
				bus_connect_change_lvl_reg <= vb3_reg;
			if (dma_rd_in)
				dma_rdata_out <= ep1_byte;
			if (reg_rd_in)
				unique case (reg_sel_in)
					REG_FLAG0: reg_rdata_out <= flag0_reg;
					REG_FLAG1: reg_rdata_out <= {4'h0, bus_connect_change_lvl_reg, flag1_reg};
					REG_SEL0:  reg_rdata_out <= sel0_reg;
					REG_SEL1:  reg_rdata_out <= {5'h00, sel1_reg};
					REG_IEN0:  reg_rdata_out <= ien0_reg;
					REG_IEN1:  reg_rdata_out <= {5'h00, ien1_reg};
					REG_EP0O:  reg_rdata_out <= ep0o_mem[ep0o_rp_reg];
					REG_SETUP: reg_rdata_out <= setup_busy ? 8'h00 : setup_mem[setup_rp_reg];
					REG_EP1:   reg_rdata_out <= ep1_byte;
					REG_SZ0:   reg_rdata_out <= ep0o_size_reg;
					REG_SZ1:   reg_rdata_out <= ep1_full_reg[ep1_rd_half_reg]
						? {1'b0, ep1_len_reg[ep1_rd_half_reg]} : 8'h00;
					default:   reg_rdata_out <= 8'h00;
				endcase
		end
	end
endmodule

// [hw/uef_host.sv]
`timescale 1ns/1ps
module uef_host
	import uef_pkg::*;
(
	// Clock, reset, enable
	input  wire logic       ref_clk_in,
	input  wire logic       resetn_in,
	input  wire logic       ce_in,
	// Link toward the device
	uef_link_if.hst         link,
	// Transaction requests
	input  wire logic       req_valid_in,
	input  wire uef_kind_e  req_kind_in,
	input  wire logic [1:0] req_ep_in,
	input  wire logic [6:0] req_len_in,
	input  wire logic       req_bad_in,
	input  wire logic       bus_reset_in,
	input  wire logic [7:0] out_data_in,
	// Results
	output logic            idle_out,
	output logic            out_take_out,
	output logic            in_valid_out,
	output logic      [7:0] in_data_out,
	output logic            done_out,
	output logic            ack_out,
	output logic            nak_out
);
	uef_host_state_e st_reg;
	logic [6:0]      len_reg, cnt_reg;
	logic            bad_reg;

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			st_reg <= HS_IDLE;
			len_reg <= 7'h00;
			cnt_reg <= 7'h00;
			bad_reg <= 1'b0;
			link.bus_reset <= 1'b0;
			link.start <= 1'b0;
			link.kind <= KIND_SETUP;
			link.ep <= 2'h0;
			link.h2d_valid <= 1'b0;
			link.h2d_data <= 8'h00;
			link.h2d_end <= 1'b0;
			link.h2d_ok <= 1'b0;
			link.h2d_ack <= 1'b0;
			idle_out <= 1'b1;
			out_take_out <= 1'b0;
			in_valid_out <= 1'b0;
			in_data_out <= 8'h00;
			done_out <= 1'b0;
			ack_out <= 1'b0;
			nak_out <= 1'b0;
		end
		else if (ce_in)
		begin
			link.bus_reset <= 1'b0;
			link.start <= 1'b0;
			link.h2d_valid <= 1'b0;
			link.h2d_end <= 1'b0;
			link.h2d_ack <= 1'b0;
			out_take_out <= 1'b0;
			in_valid_out <= 1'b0;
			done_out <= 1'b0;
			ack_out <= 1'b0;
			nak_out <= 1'b0;
			unique case (st_reg)
				HS_IDLE:
					if (bus_reset_in)
						link.bus_reset <= 1'b1;
					else if (req_valid_in)
					begin
						link.start <= 1'b1;
						link.kind <= req_kind_in;
						link.ep <= req_ep_in;
						len_reg <= req_len_in;
						bad_reg <= req_bad_in;
						cnt_reg <= 7'h00;
						idle_out <= 1'b0;
						st_reg <= (req_kind_in == KIND_IN) ? HS_WAIT : HS_DATA;
					end
				HS_DATA:
					if (cnt_reg == len_reg)
					begin
						link.h2d_end <= 1'b1;
						link.h2d_ok <= !bad_reg;
						if (bad_reg)
						begin
							done_out <= 1'b1;
							idle_out <= 1'b1;
							st_reg <= HS_IDLE;
						end
						else
							st_reg <= HS_WAIT;
					end
					else
					begin
						link.h2d_valid <= 1'b1;
						link.h2d_data <= out_data_in;
						out_take_out <= 1'b1;
						cnt_reg <= cnt_reg + 7'h01;
					end
				HS_WAIT:
				begin
					if (link.d2h_valid)
					begin
						in_valid_out <= 1'b1;
						in_data_out <= link.d2h_data;
					end
					if (link.d2h_done)
						link.h2d_ack <= 1'b1;
					if (link.d2h_done || link.d2h_ack || link.d2h_nak)
					begin
						done_out <= 1'b1;
						ack_out <= link.d2h_done || link.d2h_ack;
						nak_out <= link.d2h_nak;
						idle_out <= 1'b1;
						st_reg <= HS_IDLE;
					end
				end
				default:
					st_reg <= HS_IDLE;
			endcase
		end
	end
endmodule

// [tb/uef_link_asserts.sv]
`timescale 1ns/1ps
module uef_link_asserts
	import uef_pkg::*;
(
	// Clock and reset
	input wire logic      ref_clk_in,
	input wire logic      resetn_in,
	// Link signals
	input wire logic      start,
	input wire uef_kind_e kind,
	input wire logic      h2d_end,
	input wire logic      h2d_ok,
	input wire logic      d2h_valid,
	input wire logic      d2h_done,
	input wire logic      d2h_ack,
	input wire logic      d2h_nak
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence in_req;
		start && kind == KIND_IN;
	endsequence
	sequence in_ans;
		d2h_nak or (!d2h_nak ##1 d2h_valid);
	endsequence
	ack_cause_a: assert property (d2h_ack |-> $past(h2d_end && h2d_ok))
		else $error("ack without good end");
	ok_end_a: assert property (h2d_end && h2d_ok |=> d2h_ack ^ d2h_nak)
		else $error("no answer to good end");
	in_answer_a: assert property (in_req |=> in_ans)
		else $error("bad answer to in");
	nak_cause_a: assert property (d2h_nak |-> $past(start || h2d_end))
		else $error("nak without cause");
	hs_excl_a: assert property (!(d2h_ack && d2h_nak))
		else $error("ack and nak");
	done_pulse_a: assert property (d2h_done |=> !d2h_done && !d2h_valid)
		else $error("done not a pulse");
	ack_pulse_a: assert property (d2h_ack |=> !d2h_ack)
		else $error("ack not a pulse");
	start_quiet_a: assert property (start |=> !d2h_valid && !d2h_ack)
		else $error("early answer");
endmodule

// [tb/tb_usb_endpoint_fifo_irq_enable.sv]
`timescale 1ns/1ps
module tb_usb_endpoint_fifo_irq_enable;
	import uef_pkg::*;
	// ****
	// Stimulus and checking
	// ****
	logic clk = 0, resetn = 0, rd = 0, wr = 0, rv = 0, bus_reset_event = 0, bus_connect_change = 0, rd_d = 0;
	logic dma_rd = 0, dd = 0;
	logic [7:0] ddat;
	logic [3:0] sel = 4'h0;
	logic [7:0] wd = 8'h00, od = 8'h00, eb, rdat, idat;
	logic [1:0] ep = 2'h0;
	logic [6:0] len = 7'h00;
	uef_kind_e kd = KIND_OUT;
	logic idle, take, iv, done, ack, nak, irq0, irq1;
	logic [7:0] eq[$], dq[$];
	logic [31:0] seed = 32'h57;
	int mismatches = 0, num_checks = 0, i;
	uef_link_if lk ();
	uef_dev uef_dev_i (.ref_clk_in(clk), .resetn_in(resetn), .ce_in(1'b1), .link(lk.dev),
		.reg_sel_in(sel), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdat),
		.dma_rd_in(dma_rd), .dma_wr_in(1'b0), .dma_wdata_in(8'h00), .dma_rdata_out(ddat),
		.bus_connect_change_in(bus_connect_change), .irq0_out(irq0), .irq1_out(irq1));
	uef_host uef_host_i (.ref_clk_in(clk), .resetn_in(resetn), .ce_in(1'b1), .link(lk.hst),
		.req_valid_in(rv), .req_kind_in(kd), .req_ep_in(ep), .req_len_in(len), .req_bad_in(1'b0),
		.bus_reset_in(bus_reset_event), .out_data_in(od), .idle_out(idle), .out_take_out(take),
		.in_valid_out(iv), .in_data_out(idat), .done_out(done), .ack_out(ack), .nak_out(nak));
	uef_link_asserts uef_link_asserts_i (.ref_clk_in(clk), .resetn_in(resetn), .start(lk.start),
		.kind(lk.kind), .h2d_end(lk.h2d_end), .h2d_ok(lk.h2d_ok), .d2h_valid(lk.d2h_valid),
		.d2h_done(lk.d2h_done), .d2h_ack(lk.d2h_ack), .d2h_nak(lk.d2h_nak));
	always #5 clk = ~clk;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic rw(input logic r, input logic [3:0] s, input logic [7:0] d);
		@(negedge clk);
		sel = s;
		wd = d;
		rd = r;
		wr = !r;
		if (r)
			eq.push_back(d);
		@(negedge clk);
		rd = 0;
		wr = 0;
	endtask
	task automatic xact(input uef_kind_e k, input logic [6:0] n, input logic [7:0] h);
		@(negedge clk);
		kd = k;
		len = n;
		rv = 1;
		eq.push_back(h);
		@(negedge clk);
		rv = 0;
		for (i = 0; i < 200 && done !== 1'b1; i++)
			@(negedge clk);
		if (i == 200)
		begin
			mismatches++;
			print_verdict();
		end
		@(negedge clk);
	endtask
	task automatic dmar();
		@(negedge clk);
		dma_rd = 1;
		eq.push_back(dq.pop_front());
		@(negedge clk);
		dma_rd = 0;
	endtask
	task automatic irqc(input logic [1:0] e, input int n);
		repeat (n) @(negedge clk);
		chk({6'h00, irq1, irq0}, {6'h00, e});
	endtask
	always @(posedge clk)
	begin
		rd_d <= rd;
		dd <= dma_rd;
	end
	always @(negedge clk)
	begin
		if (rd_d)
			chk(rdat, eq.pop_front());
		if (dd)
			chk(ddat, eq.pop_front());
		if (iv === 1'b1)
			chk(idat, eq.pop_front());
		if (done === 1'b1)
		begin
			chk({6'h00, ack, nak}, eq.pop_front());
			chk({7'h00, idle}, 8'h01);
		end
		if (take === 1'b1)
			dq.push_back(od);
		od <= xs();
	end
	initial
	begin
		repeat (16) @(negedge clk);
		resetn = 1;
		rw(1, REG_IEN0, 8'h10);
		rw(1, REG_IEN1, 8'h00);
		rw(1, REG_SZ0, 8'h00);
		rw(1, REG_SZ1, 8'h00);
		rw(0, REG_IEN1, 8'h07);
		rw(1, REG_IEN1, 8'h07);
		bus_reset_event = 1;
		@(negedge clk);
		bus_reset_event = 0;
		repeat (4) @(negedge clk);
		rw(1, REG_FLAG0, 8'h80);
		$display("test registers done");
		bus_connect_change = 1;
		irqc(2'b10, 8);
		rw(0, REG_SEL1, 8'h00);
		irqc(2'b01, 4);
		rw(0, REG_FLAG1, 8'h0E);
		irqc(2'b00, 4);
		$display("test irq done");
		xact(KIND_OUT, 7'h08, 8'h02);
		rw(1, REG_SZ0, 8'h08);
		xact(KIND_OUT, 7'h02, 8'h01);
		repeat (8) rw(1, REG_EP0O, dq.pop_front());
		rw(0, REG_TRIG, 8'h02);
		xact(KIND_OUT, 7'h03, 8'h02);
		rw(1, REG_SZ0, 8'h03);
		rw(0, REG_FIFO_CLEAR_REG, 8'h02);
		rw(1, REG_FLAG0, 8'h84);
		xact(KIND_OUT, 7'h01, 8'h02);
		$display("test out done");
		for (int j = 0; j < 3; j++)
		begin
			eb = xs();
			eq.push_back(eb);
			rw(0, REG_EP0I, eb);
		end
		rw(0, REG_TRIG, 8'h01);
		xact(KIND_IN, 7'h00, 8'h02);
		rw(1, REG_FLAG0, 8'h85);
		$display("test in done");
		dq.delete();
		xact(KIND_SETUP, 7'h08, 8'h02);
		repeat (8) rw(1, REG_SETUP, dq.pop_front());
		rw(0, REG_TRIG, 8'h04);
		ep = EP_BULK_RX;
		dq.delete();
		xact(KIND_OUT, 7'h04, 8'h02);
		rw(1, REG_SZ1, 8'h04);
		dmar();
		rw(1, REG_EP1, dq.pop_front());
		rw(1, REG_FLAG0, 8'hCD);
		rw(0, REG_TRIG, 8'h20);
		rw(1, REG_SZ1, 8'h00);
		$display("test setup and bulk done");
		print_verdict();
	end
endmodule
